// ---- logic/arex_regs.v ----
`timescale 1ns/1ps
`include "arex_defs.vh"
// Behaviour
// R1: Positive buffer bypass bit resets to 0; 1 bypasses the buffer.
// R2: Negative buffer bypass bit resets to 1; writing 0 enables it.
// R3: Select 00 first pair, 01 second pair, 10 internal, 11 reserved.
// R4: Internal config resets to 00 off; 01 on but off in power-down.
// R5: Internal config 10 is always on; 11 is reserved.
// R6: Host should bypass both buffers when the internal source is used.
// R7: Host turns the internal source on before enabling excitation.
// R8: Magnitude register at 06h resets to 00h, both sources off.
// R9: Host writes zeros in magnitude bits 7:4; they reset to zero.
// R10: Magnitude 0 off, 1 to 9 give 10 to 2000 uA, 10 to 15 off.
// R11: One magnitude code drives both excitation sources alike.
// R12: Routing register at 07h resets to FFh.
module arex_regs (
    input wire clk_sys_in, // System clock, 10 MHz
    input wire reset_n_in, // Async reset, low
    input wire ce_in, // Clock enable
    input wire [31:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output wire s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write strobes
    input wire s_axi_wvalid, // Write data valid
    output wire s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [31:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output wire s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read valid
    input wire s_axi_rready, // Read ready
    input wire power_down_in, // Device in power-down
    output reg positive_buffer_bypass_out, // 1 bypasses pos buffer
    output reg negative_buffer_bypass_out, // 1 bypasses neg buffer
    output reg [1:0] reference_input_select_out, // Reference source
    output reg select_reserved_out, // Reserved select code held
    output reg internal_source_on_out, // Internal source powered
    output reg config_reserved_out, // Reserved config code held
    output reg [3:0] excitation_source_one_out, // Source one code
    output reg [3:0] excitation_source_two_out, // Source two code
    output reg excitation_enable_out, // Sources carry current
    output reg [7:0] excitation_routing_out // Routing register
);
    // ----------------------------------------
    // Write channel capture
    // ----------------------------------------
    reg aw_held_q;
    reg [7:0] aw_addr_q;
    reg w_held_q;
    reg [7:0] w_data_q;
    reg w_lane_q;
    wire wr_fire;
    wire [7:0] wr_addr;
    wire wr_map;

    // Hold off new write halves until the response drains
    // Readies low while frozen so no taken half is lost
    assign s_axi_awready = ce_in && !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = ce_in && !w_held_q && !s_axi_bvalid;
    assign wr_fire = aw_held_q && w_held_q;
    assign wr_addr = aw_addr_q;
    assign wr_map = (wr_addr == `AREX_VOLTAGE_SOURCE_ADDR) ||
                    (wr_addr == `AREX_EXC_MAGNITUDE_ADDR) ||
                    (wr_addr == `AREX_EXC_ROUTING_ADDR);

    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AREX_RESP_OKAY;
        end else if (ce_in) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                // Word index; address bits above 9 alias
                aw_addr_q <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `AREX_RESP_OKAY
                                      : `AREX_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    wire wr_ok;
    wire [7:0] vsrc_q;
    wire [7:0] mag_q;
    wire [7:0] route_q;

    // Only lane 0 carries the 8-bit registers
    assign wr_ok = wr_fire && wr_map && w_lane_q;

    arex_reg8 #(
        .RESET_VAL(`AREX_VOLTAGE_SOURCE_RST) // see R1 see R2 see R4
    ) u_vsrc (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .wr_in(wr_ok && wr_addr == `AREX_VOLTAGE_SOURCE_ADDR),
        .data_in(w_data_q),
        .value_out(vsrc_q)
    );

    // Upper bits stored as written; host keeps them zero
    arex_reg8 #(
        .RESET_VAL(`AREX_EXC_MAGNITUDE_RST) // see R8 see R9
    ) u_mag (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .wr_in(wr_ok && wr_addr == `AREX_EXC_MAGNITUDE_ADDR), // see R8
        .data_in(w_data_q),
        .value_out(mag_q)
    );

    arex_reg8 #(
        .RESET_VAL(`AREX_EXC_ROUTING_RST) // see R12
    ) u_route (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .wr_in(wr_ok && wr_addr == `AREX_EXC_ROUTING_ADDR), // see R12
        .data_in(w_data_q),
        .value_out(route_q)
    );

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    assign s_axi_arready = ce_in && !s_axi_rvalid;

    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AREX_RESP_OKAY;
        end else if (ce_in) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `AREX_RESP_OKAY;
                case (s_axi_araddr[9:2])
                    `AREX_VOLTAGE_SOURCE_ADDR: begin
                        s_axi_rdata <= {24'h000000, vsrc_q};
                    end
                    `AREX_EXC_MAGNITUDE_ADDR: begin
                        s_axi_rdata <= {24'h000000, mag_q};
                    end
                    `AREX_EXC_ROUTING_ADDR: begin
                        s_axi_rdata <= {24'h000000, route_q};
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `AREX_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Field decode to analog controls
    // ----------------------------------------
    wire [1:0] sel_f;
    wire [1:0] cfg_f;
    wire [3:0] mag_f;
    wire mag_on;
    reg src_on;

    assign sel_f = vsrc_q[`AREX_SEL_HI:`AREX_SEL_LO];
    assign cfg_f = vsrc_q[`AREX_CFG_HI:`AREX_CFG_LO];
    assign mag_f = mag_q[3:0];
    // Codes above nine are treated as off, not clamped
    assign mag_on = (mag_f != 4'h0) && (mag_f <= `AREX_MAG_MAX); // see R10

    always @* begin
        case (cfg_f)
            `AREX_CFG_OFF: src_on = 1'b0; // see R4
            `AREX_CFG_ON_PD: src_on = !power_down_in; // see R4
            `AREX_CFG_ALWAYS: src_on = 1'b1; // see R5
            default: src_on = 1'b0; // see R5
        endcase
    end

    // Outputs registered so the analog side sees clean levels
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            positive_buffer_bypass_out <= 1'b0;
            negative_buffer_bypass_out <= 1'b1;
            reference_input_select_out <= `AREX_SEL_FIRST;
            select_reserved_out <= 1'b0;
            internal_source_on_out <= 1'b0;
            config_reserved_out <= 1'b0;
            excitation_source_one_out <= 4'h0;
            excitation_source_two_out <= 4'h0;
            excitation_enable_out <= 1'b0;
            excitation_routing_out <= `AREX_EXC_ROUTING_RST;
        end else if (ce_in) begin
            positive_buffer_bypass_out <= vsrc_q[`AREX_POS_BUF_BIT]; // see R1
            negative_buffer_bypass_out <= vsrc_q[`AREX_NEG_BUF_BIT]; // see R2
            reference_input_select_out <= sel_f; // see R3
            select_reserved_out <= (sel_f == 2'h3); // see R3
            internal_source_on_out <= src_on;
            config_reserved_out <= (cfg_f == 2'h3); // see R5
            // Same code to both sources keeps them matched
            excitation_source_one_out <= mag_on ? mag_f : 4'h0; // see R11
            excitation_source_two_out <= mag_on ? mag_f : 4'h0; // see R11
            excitation_enable_out <= mag_on; // see R10
            excitation_routing_out <= route_q;
        end
    end
endmodule

// ---- inc/arex_defs.vh ----
`ifndef AREX_DEFS_VH
`define AREX_DEFS_VH
// ----------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------
`define AREX_VOLTAGE_SOURCE_ADDR 8'h05
`define AREX_EXC_MAGNITUDE_ADDR 8'h06
`define AREX_EXC_ROUTING_ADDR 8'h07
// ----------------------------------------
// Reset values
// ----------------------------------------
`define AREX_VOLTAGE_SOURCE_RST 8'h10
`define AREX_EXC_MAGNITUDE_RST 8'h00
`define AREX_EXC_ROUTING_RST 8'hFF
// ----------------------------------------
// Field positions in the voltage source register
// ----------------------------------------
`define AREX_POS_BUF_BIT 5
`define AREX_NEG_BUF_BIT 4
`define AREX_SEL_HI 3
`define AREX_SEL_LO 2
`define AREX_CFG_HI 1
`define AREX_CFG_LO 0
// ----------------------------------------
// Field codes
// ----------------------------------------
`define AREX_SEL_FIRST 2'h0
`define AREX_SEL_SECOND 2'h1
`define AREX_SEL_INTERNAL 2'h2
`define AREX_CFG_OFF 2'h0
`define AREX_CFG_ON_PD 2'h1
`define AREX_CFG_ALWAYS 2'h2
`define AREX_MAG_MAX 4'h9
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define AREX_RESP_OKAY 2'h0
`define AREX_RESP_SLVERR 2'h2
`endif

// ---- logic/arex_reg8.v ----
`timescale 1ns/1ps
// ----------------------------------------
// One 8-bit register with reset value
// ----------------------------------------
module arex_reg8 #(
    parameter [7:0] RESET_VAL = 8'h00
) (
    input wire clk_sys_in, // System clock
    input wire reset_n_in, // Async reset, low
    input wire ce_in, // Clock enable
    input wire wr_in, // Write strobe
    input wire [7:0] data_in, // Write data
    output reg [7:0] value_out // Stored value
);
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            value_out <= RESET_VAL;
        end else if (ce_in && wr_in) begin
            value_out <= data_in;
        end
    end
endmodule

// ---- bench/arex_regs_sva.sv ----
`timescale 1ns/1ps
module arex_regs_chk (
    input wire clk_sys_in, // Clock
    input wire reset_n_in, // Reset, low
    input wire ce_in, // Clock enable
    input wire s_axi_awvalid, // AW valid
    input wire s_axi_awready, // AW ready
    input wire s_axi_wvalid, // W valid
    input wire s_axi_wready, // W ready
    input wire s_axi_bvalid, // B valid
    input wire s_axi_bready, // B ready
    input wire s_axi_arvalid, // AR valid
    input wire s_axi_arready, // AR ready
    input wire s_axi_rvalid, // R valid
    input wire positive_buffer_bypass_out, // Pos bypass
    input wire negative_buffer_bypass_out, // Neg bypass
    input wire internal_source_on_out, // Source on
    input wire config_reserved_out, // Reserved cfg
    input wire [3:0] excitation_source_one_out, // Source one
    input wire [3:0] excitation_source_two_out, // Source two
    input wire excitation_enable_out, // Sources on
    input wire [7:0] excitation_routing_out // Routing
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_done;
        s_axi_bvalid && s_axi_bready;
    endsequence
    a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read not answered");
    a_b_once: assert property (s_b_done |=> !s_axi_bvalid)
        else $error("write answered twice");
    a_src_same: assert property (excitation_source_one_out ==
        excitation_source_two_out) else $error("sources differ");
    a_mag_enable: assert property (excitation_enable_out ==
        ((excitation_source_one_out != 4'h0) &&
        (excitation_source_one_out <= 4'h9))) else $error("bad magnitude");
    a_ce_freeze: assert property (!ce_in |->
        !s_axi_awready && !s_axi_wready && !s_axi_arready)
        else $error("frozen block took a request");
    a_cfg_rsv: assert property (config_reserved_out |->
        !internal_source_on_out) else $error("reserved code powers on");
    a_rst_ref: assert property ($rose(reset_n_in) |->
        !positive_buffer_bypass_out && negative_buffer_bypass_out)
        else $error("bypass reset wrong");
    a_rst_exc: assert property ($rose(reset_n_in) |->
        excitation_routing_out == 8'hFF && !excitation_enable_out)
        else $error("excitation reset wrong");
endmodule
bind arex_regs arex_regs_chk i_chk (.*);

// ---- bench/arex_regs_tb.sv ----
`timescale 1ns/1ps
`include "arex_defs.vh"
module arex_regs_tb;
    localparam [1:0] OK = `AREX_RESP_OKAY;
    localparam [1:0] ERR = `AREX_RESP_SLVERR;
    logic clk_sys_in = '0, reset_n_in = '0, ce_in = '1, power_down_in = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = '0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, positive_buffer_bypass_out, select_reserved_out;
    wire negative_buffer_bypass_out, internal_source_on_out;
    wire config_reserved_out, excitation_enable_out;
    wire [1:0] s_axi_bresp, s_axi_rresp, reference_input_select_out;
    wire [3:0] excitation_source_one_out, excitation_source_two_out;
    wire [7:0] excitation_routing_out;
    wire [31:0] s_axi_rdata;
    int num_errors = 0, checks = 0;
    arex_regs i_dut (.*);
    always #50 clk_sys_in = ~clk_sys_in;
    task chk(input [31:0] got, input [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d, input [3:0] s, input [1:0] e);
        logic aw_done;
        logic w_done;
        @(posedge clk_sys_in);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        aw_done = 1'h0;
        w_done = 1'h0;
        // Each half is released at the edge that takes it
        while (!(aw_done && w_done)) begin
            @(posedge clk_sys_in);
            if (!aw_done && s_axi_awready === 1'h1) begin
                aw_done = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_done && s_axi_wready === 1'h1) begin
                w_done = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge clk_sys_in); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, e);
    endtask
    task rd(input [7:0] a, input [31:0] d, input [1:0] e);
        @(posedge clk_sys_in);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk_sys_in); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk_sys_in); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, e);
    endtask
    task t_reset;
        chk(positive_buffer_bypass_out, 1'h0);
        chk(negative_buffer_bypass_out, 1'h1);
        chk(reference_input_select_out, `AREX_SEL_FIRST);
        chk(internal_source_on_out, 1'h0);
        chk(excitation_enable_out, 1'h0);
        chk(excitation_routing_out, 8'hFF);
        rd(8'h14, 32'h10, OK);
        rd(8'h18, 32'h00, OK);
        rd(8'h1C, 32'hFF, OK);
    endtask
    task t_ref;
        logic [7:0] v;
        logic e;
        for (int i = 0; i < 32; i++) begin
            v = {2'h0, i[2] ^ i[0], i[1], i[3:0]};
            e = (v[1:0] == 2'h2) || (v[1:0] == 2'h1 && !i[4]);
            power_down_in <= i[4];
            wr(8'h14, v, 4'h1, OK);
            // Decoded outputs lag the register by one edge
            @(posedge clk_sys_in);
            chk(positive_buffer_bypass_out, v[5]);
            chk(negative_buffer_bypass_out, v[4]);
            chk(reference_input_select_out, v[3:2]);
            chk(select_reserved_out, v[3:2] == 2'h3);
            chk(internal_source_on_out, e);
            chk(config_reserved_out, v[1:0] == 2'h3);
            rd(8'h14, {24'h0, v}, OK);
        end
    endtask
    task t_mag;
        logic [3:0] m;
        for (int i = 0; i < 16; i++) begin
            m = i[3:0];
            wr(8'h18, {4'h0, m}, 4'h1, OK);
            @(posedge clk_sys_in);
            chk(excitation_source_one_out, m <= 4'h9 ? m : 4'h0);
            chk(excitation_source_two_out, m <= 4'h9 ? m : 4'h0);
            chk(excitation_enable_out, m != 4'h0 && m <= 4'h9);
            rd(8'h18, {28'h0, m}, OK);
        end
    endtask
    task t_bus;
        wr(8'h1C, 8'h5A, 4'h1, OK);
        // A cleared strobe must leave the register alone
        wr(8'h1C, 8'hC3, 4'h0, OK);
        @(posedge clk_sys_in);
        chk(excitation_routing_out, 8'h5A);
        wr(8'h20, 8'h01, 4'h1, ERR);
        rd(8'h10, 32'h0, ERR);
        rd(8'h18, 32'h0F, OK);
        rd(8'h1C, 32'h5A, OK);
    endtask
    task t_freeze;
        @(posedge clk_sys_in);
        ce_in <= 1'h0;
        fork
            wr(8'h18, 8'h03, 4'h1, OK);
            begin
                repeat (4) @(posedge clk_sys_in);
                // Frozen block neither takes the request nor moves
                chk(s_axi_awready, 1'h0);
                chk(excitation_enable_out, 1'h0);
                ce_in <= 1'h1;
            end
        join
        @(posedge clk_sys_in);
        chk(excitation_source_one_out, 4'h3);
        chk(excitation_source_two_out, 4'h3);
        // Reset in mid-run brings back every reset value
        reset_n_in <= 1'h0;
        repeat (2) @(posedge clk_sys_in);
        reset_n_in <= 1'h1;
        @(posedge clk_sys_in);
        chk(excitation_routing_out, 8'hFF);
        chk(excitation_source_one_out, 4'h0);
        chk(negative_buffer_bypass_out, 1'h1);
        rd(8'h14, 32'h10, OK);
        rd(8'h18, 32'h00, OK);
        rd(8'h1C, 32'hFF, OK);
    endtask
    task end_sim;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_in);
        reset_n_in <= 1'h1;
        @(posedge clk_sys_in);
        t_reset;
        t_ref;
        wr(8'h14, 8'h3A, 4'h1, OK);
        t_mag;
        t_bus;
        t_freeze;
        end_sim;
    end
    initial begin
        #2000000;
        num_errors++;
        end_sim;
    end
endmodule
